// ==== rtl/pic_defs.svh ====
/*
 checksum block constants: masks, widths, term counts.
 assumes inclusion by bare name from the package and module.
*/
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_SUM_W 16
`define PIC_WORD_W 14
`define PIC_CFG_MASK 14'h3BFF
`define PIC_NIB_MASK 14'h000F
`define PIC_ID_COUNT 4
`endif

// ==== rtl/pic_pkg.sv ====
/*
 types for the program image checksum block.
 assumes pic_defs.svh is on the include path.
*/
`include "pic_defs.svh"
package pic_pkg;
    typedef enum logic [3:0] {
        PIC_KIND_PROG = 4'h1,
        PIC_KIND_CFG = 4'h2,
        PIC_KIND_ID = 4'h4,
        PIC_KIND_LAST = 4'h8
    } pic_kind_t;
    typedef struct packed {
        logic [`PIC_WORD_W-1:0] data;
        logic [1:0] kind;
        logic last;
    } pic_word_t;
    typedef enum logic [2:0] {
        PIC_ST_IDLE = 3'b001,
        PIC_ST_RUN = 3'b010,
        PIC_ST_DONE = 3'b100
    } pic_state_t;
endpackage

// ==== rtl/pic_checksum.sv ====
/*
 program image checksum accumulator.
 assumes the word source presents program words, the configuration word and four id
 locations as it reads them; kind codes: 0 program, 1 configuration, 2 id location.
*/
// Notes on behaviour
// (R1) checksum sums program words, masked configuration word and id term
// (R2) only low 16 bits of the total kept, carries dropped
// (R3) configuration word is anded with 0x3BFF before adding
// (R4) id term packs four low nibbles, first id location most significant
// (R5) full protection: only masked configuration word plus id term summed
// (R6) code-protect setting selects which terms are summed
// (R7) reader of a real device may sum program memory as returned
// (R8) configuration word and id locations are always readable
// (R9) one 14-bit word per valid cycle, done after the last term
`timescale 1ns/1ns
`include "pic_defs.svh"
module pic_checksum (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic prog_included,
    input wire logic id_included,
    input wire logic word_valid,
    input wire pic_pkg::pic_word_t word_in,
    output logic [15:0] checksum,
    output logic done
);
    import pic_pkg::*;

    pic_state_t state, next_state;
    logic [`PIC_SUM_W-1:0] acc, next_acc;
    logic [`PIC_SUM_W-1:0] id_term, next_id_term;
    logic [1:0] id_count, next_id_count;
    logic [`PIC_SUM_W-1:0] checksum_q, next_checksum;
    logic done_q, next_done;
    logic [`PIC_SUM_W-1:0] term;
    logic take;
    logic begin_run;

    // the carry lands in bit 16 of the wider add and the return slice drops it
    function automatic logic [`PIC_SUM_W-1:0] add16(input logic [`PIC_SUM_W-1:0] a,
                                                   input logic [`PIC_SUM_W-1:0] b);
        logic [`PIC_SUM_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[`PIC_SUM_W-1:0]; // see (R2)
    endfunction

    // reserved configuration bits never reach the sum
    function automatic logic [`PIC_SUM_W-1:0] cfg_term(input logic [`PIC_WORD_W-1:0] d);
        return {2'b00, d & `PIC_CFG_MASK}; // see (R3)
    endfunction

    // words outside a frame are dropped, no port reports it
    assign take = (state == PIC_ST_RUN) && word_valid; // see (R9)
    assign begin_run = (state == PIC_ST_IDLE || state == PIC_ST_DONE) && start;

    always_comb begin
        term = '0;
        case (word_in.kind)
            2'd0: term = prog_included ? {2'b00, word_in.data} : '0; // see (R5) (R6) (R7)
            2'd1: term = cfg_term(word_in.data); // see (R3) (R8)
            default: term = '0; // id words count only through the packed term
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            PIC_ST_IDLE: begin
                if (start) begin
                    next_state = PIC_ST_RUN;
                end
            end
            PIC_ST_RUN: begin
                if (take && word_in.last) begin
                    next_state = PIC_ST_DONE;
                end
            end
            PIC_ST_DONE: begin
                if (start) begin
                    next_state = PIC_ST_RUN;
                end
            end
            default: begin
                next_state = PIC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= PIC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_acc = acc;
        if (begin_run) begin
            next_acc = '0;
        end else if (take) begin
            next_acc = add16(acc, term); // see (R1) (R2)
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    always_comb begin
        next_id_term = id_term;
        next_id_count = id_count;
        if (begin_run) begin
            next_id_term = '0;
            next_id_count = '0;
        end else if (take && word_in.kind == 2'd2) begin
            // nibbles shift in, first location ends most significant
            next_id_term = {id_term[11:0], word_in.data[3:0]}; // see (R4)
            next_id_count = id_count + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            id_term <= '0;
            id_count <= '0;
        end else begin
            id_term <= next_id_term;
            id_count <= next_id_count;
        end
    end

    always_comb begin
        next_checksum = checksum_q;
        next_done = 1'b0;
        if (take && word_in.last) begin
            // full protection: prog_included low, id_included high, see (R5)
            next_checksum = id_included ? add16(next_acc, next_id_term) : next_acc; // see (R1) (R6)
            next_done = 1'b1; // see (R9)
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            checksum_q <= '0;
            done_q <= 1'b0;
        end else begin
            checksum_q <= next_checksum;
            done_q <= next_done;
        end
    end

    assign checksum = checksum_q;
    assign done = done_q;

    chk_done_after_last: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        (state == PIC_ST_RUN && word_valid && word_in.last) |=> done)
        else $error("done missing after last term");
    chk_done_single: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        done |=> !done)
        else $error("done longer than one cycle");
    chk_cfg_masked: assert property (@(posedge clk) disable iff (!reset_n) // see (R3)
        (state == PIC_ST_RUN && word_valid && word_in.kind == 2'd1 && !word_in.last)
        |=> acc == add16($past(acc), cfg_term($past(word_in.data))))
        else $error("configuration word not masked");
    chk_prog_skip: assert property (@(posedge clk) disable iff (!reset_n) // see (R5)
        (state == PIC_ST_RUN && word_valid && word_in.kind == 2'd0 && !prog_included && !word_in.last)
        |=> $stable(acc))
        else $error("program word summed while protected");
    chk_prog_add: assert property (@(posedge clk) disable iff (!reset_n) // see (R1)
        (state == PIC_ST_RUN && word_valid && word_in.kind == 2'd0 && prog_included && !word_in.last)
        |=> acc == add16($past(acc), {2'b00, $past(word_in.data)}))
        else $error("program word not added");
    chk_id_pack: assert property (@(posedge clk) disable iff (!reset_n) // see (R4)
        (state == PIC_ST_RUN && word_valid && word_in.kind == 2'd2)
        |=> id_term[3:0] == $past(word_in.data[3:0]) && id_term[15:4] == $past(id_term[11:0]))
        else $error("id nibble packing wrong");
    chk_start_clears: assert property (@(posedge clk) disable iff (!reset_n) // see (R2)
        (state != PIC_ST_RUN && start) |=> acc == 16'h0000 && id_term == 16'h0000)
        else $error("start did not clear accumulator");
    chk_sum_hold: assert property (@(posedge clk) disable iff (!reset_n) // see (R1)
        (!done && !(state == PIC_ST_RUN && word_valid && word_in.last)) |=> $stable(checksum))
        else $error("checksum changed without last term");
    chk_state_onehot: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        $onehot(state))
        else $error("state not one-hot");
    chk_outside_ignored: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        (state != PIC_ST_RUN && !start) |=> $stable(acc) && $stable(id_term))
        else $error("word taken outside a frame");
    chk_run_start_ignored: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        (state == PIC_ST_RUN && start && !word_valid) |=> $stable(acc))
        else $error("start acted during a frame");
    chk_spare_kind_noop: assert property (@(posedge clk) disable iff (!reset_n) // see (R1)
        (take && word_in.kind == 2'd3 && !word_in.last) |=> $stable(acc) && $stable(id_term))
        else $error("spare kind changed the sum");
    chk_id_no_add: assert property (@(posedge clk) disable iff (!reset_n) // see (R4)
        (take && word_in.kind == 2'd2 && !word_in.last) |=> $stable(acc))
        else $error("id word added directly");
    chk_final_value: assert property (@(posedge clk) disable iff (!reset_n) // see (R1) (R5)
        (take && word_in.last) |=> checksum == ($past(id_included) ? add16(acc, id_term) : acc))
        else $error("final checksum wrong");
    chk_id_count_step: assert property (@(posedge clk) disable iff (!reset_n) // see (R4)
        (take && word_in.kind == 2'd2) |=> id_count == 2'($past(id_count) + 2'd1))
        else $error("id count did not step");
    chk_id_count_clear: assert property (@(posedge clk) disable iff (!reset_n) // see (R4)
        begin_run |=> id_count == 2'd0)
        else $error("id count not cleared");
    chk_done_from_run: assert property (@(posedge clk) disable iff (!reset_n) // see (R9)
        $rose(done) |-> $past(state) == PIC_ST_RUN)
        else $error("done raised outside a frame");
endmodule // pic_checksum

// ==== tb/pic_reader_model.sv ====
/* programmer-side word source model.
 assumes the bench calls put_word once a clock. */
`timescale 1ns/1ns
module pic_reader_model (
    input wire logic clk,
    output logic word_valid,
    output pic_pkg::pic_word_t word_in
);
    import pic_pkg::*;
    initial begin
        word_valid = 1'b0;
        word_in = '0;
    end
    // memory words go out as read; cfg and ids always readable
    task automatic put_word(input logic [13:0] d, input logic [1:0] k, input logic l);
        @(negedge clk);
        word_valid <= 1'b1;
        word_in <= '{data: d, kind: k, last: l};
    endtask
    // released bus shows inverted data so stale words cannot pass
    task automatic idle();
        @(negedge clk);
        word_valid <= 1'b0;
        word_in <= ~word_in;
    endtask
endmodule // pic_reader_model

// ==== tb/test_pic_checksum.sv ====
/* self-checking bench for pic_checksum.
 assumes pic_reader_model drives words; 10 MHz clock. */
`timescale 1ns/1ns
module test_pic_checksum;
    import pic_pkg::*;
    logic clk, reset_n, start, prog_included, id_included, word_valid, done;
    pic_word_t word_in;
    logic [15:0] checksum;
    int mismatches = 0, compares = 0, seed = 18843;
    pic_checksum dut_u (.clk(clk), .reset_n(reset_n), .start(start), .prog_included(prog_included),
        .id_included(id_included), .word_valid(word_valid), .word_in(word_in), .checksum(checksum), .done(done));
    pic_reader_model model_u (.clk(clk), .word_valid(word_valid), .word_in(word_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_flag(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] expect_sum(input logic [13:0] p[8], input int n, input logic [13:0] c,
            input logic [13:0] id[4], input logic pi, input logic ii);
        logic [15:0] s;
        s = {2'h0, c & 14'h3BFF};
        for (int i = 0; i < n; i++) if (pi) s = s + {2'h0, p[i]}; // carries dropped
        if (ii) s = s + {id[0][3:0], id[1][3:0], id[2][3:0], id[3][3:0]};
        return s;
    endfunction
    initial begin
        #(100 * 2000);
        mismatches++;
        give_verdict();
    end
    initial begin
        logic [13:0] p[8];
        logic [13:0] id[4];
        logic [13:0] c;
        logic [31:0] r;
        int n;
        reset_n = 1'b0;
        start = 1'b0;
        prog_included = 1'b0;
        id_included = 1'b0;
        repeat (8) @(negedge clk);
        chk("checksum", 16'h0000, checksum);
        chk_flag("done", 1'b0, done);
        reset_n = 1'b1;
        for (int t = 0; t < 24; t++) begin
            // first two: all-ones image forces carries, with and without memory
            r = $random(seed);
            n = (t < 2) ? 8 : 1 + r[2:0];
            for (int i = 0; i < 8; i++) begin r = $random(seed); p[i] = (t < 2) ? 14'h3FFF : r[13:0]; end
            for (int i = 0; i < 4; i++) begin r = $random(seed); id[i] = (t < 2) ? 14'h3FFF : r[13:0]; end
            r = $random(seed);
            c = (t < 2) ? 14'h3FFF : r[13:0];
            model_u.put_word(r[13:0], 2'h0, 1'b1); // refused outside a frame
            model_u.idle();
            @(negedge clk);
            chk_flag("done", 1'b0, done);
            start <= 1'b1;
            prog_included <= (t < 2) ? ~t[0] : r[14];
            id_included <= (t < 2) ? 1'b1 : r[15];
            @(negedge clk);
            start <= 1'b0;
            for (int i = 0; i < n; i++) model_u.put_word(p[i], 2'h0, 1'b0);
            model_u.put_word(c, 2'h1, 1'b0);
            model_u.put_word(r[13:0], 2'h3, 1'b0); // spare kind adds nothing
            for (int i = 0; i < 4; i++) model_u.put_word(id[i], 2'h2, i == 3);
            model_u.idle();
            chk_flag("done", 1'b1, done);
            chk("checksum", expect_sum(p, n, c, id, prog_included, id_included), checksum);
            @(negedge clk);
            chk_flag("done", 1'b0, done);
            $display("test %0d ended", t);
        end
        // reset inside a frame drops the partial sum
        @(negedge clk);
        start <= 1'b1;
        prog_included <= 1'b1;
        id_included <= 1'b0;
        @(negedge clk);
        start <= 1'b0;
        model_u.put_word(14'h3FFF, 2'h1, 1'b0);
        model_u.put_word(14'h3FFF, 2'h2, 1'b0);
        reset_n <= 1'b0;
        model_u.idle();
        @(negedge clk);
        reset_n <= 1'b1;
        chk("checksum", 16'h0000, checksum);
        chk_flag("done", 1'b0, done);
        @(negedge clk);
        start <= 1'b1;
        @(negedge clk);
        start <= 1'b0;
        model_u.put_word(14'h3FFF, 2'h1, 1'b1);
        model_u.idle();
        chk_flag("done", 1'b1, done);
        chk("checksum", 16'h3BFF, checksum);
        $display("test reset ended");
        give_verdict();
    end
endmodule // test_pic_checksum
